// file: shared/rx_cfg_pkg.sv
// constants and field positions for the receive configuration bank
//
// Operation
// - bit 7 set freezes AGC during packet
// - bit 6 gates estimator clock until detect
// - bits 5,4 at zero enable both equalizers
// - bit 3 picks CRC16 or SFD ready point
// - bit 2 stops diversity in slot's last half
// - single antenna drives select pin from bit 1
// - bit 0 picks dual or single antenna acquire
// - continuous clocks bit overrides estimator gating
// - bit 6 selects DC or AC coupling
// - bit 4 uses long length for short preamble
// - raw mode CCA follows detector inputs one cycle later
// - sampled CCA updates once per 20us slot
// - bits 2:0 give the precursor value
// - bit 7 clocks converters from serial pin
// - bits 6:0 stop individual converter clocks
// - bit 0 enables manual power-down from bits
// - bits 7..1 set standby, dozes, shutdowns
// - else power follows reset and enables
// - bit 7 selects two's complement or offset binary
// - bits 6:4 select the I/Q DAC source
// - source 101 circulates weights with sync pulse
// - sources 110, 111 give test bus, correlator
// - sample point 18.7us or 15.8us per setting
package rx_cfg_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RX_CFG = 8'h14;
    localparam logic [7:0] IDX_RXTX_CFG = 8'h16;
    localparam logic [7:0] IDX_CONV_CLK = 8'h18;
    localparam logic [7:0] IDX_CONV_PWR = 8'h1a;
    localparam logic [7:0] IDX_CONV_FMT = 8'h1c;
    localparam logic [7:0] ADDR_RX_CFG = 8'(IDX_RX_CFG * 4);
    localparam logic [7:0] ADDR_RXTX_CFG = 8'(IDX_RXTX_CFG * 4);
    localparam logic [7:0] ADDR_CONV_CLK = 8'(IDX_CONV_CLK * 4);
    localparam logic [7:0] ADDR_CONV_PWR = 8'(IDX_CONV_PWR * 4);
    localparam logic [7:0] ADDR_CONV_FMT = 8'(IDX_CONV_FMT * 4);

    localparam logic [7:0] RST_RX_CFG = 8'h00;
    localparam logic [7:0] RST_RXTX_CFG = 8'h00;
    localparam logic [7:0] RST_CONV_CLK = 8'h00;
    localparam logic [7:0] RST_CONV_PWR = 8'h00;
    localparam logic [7:0] RST_CONV_FMT = 8'h00;

    // receive configure fields
    localparam int RX_AGC_FREEZE = 7;
    localparam int RX_EST_AFTER_DETECT = 6;
    localparam int RX_ISI_OFF = 5;
    localparam int RX_ICI_OFF = 4;
    localparam int RX_READY_AT_SFD = 3;
    localparam int RX_SLOT_DIV = 2;
    localparam int RX_ANT_CHOICE = 1;
    localparam int RX_SINGLE_ANT = 0;
    // rx-tx configure fields
    localparam int RT_CONT_CLK = 7;
    localparam int RT_AC_COUPLE = 6;
    localparam int RT_LONG_FOR_SHORT = 4;
    localparam int RT_CCA_SAMPLED = 3;
    localparam int RT_PRECURSOR_HI = 2;
    // converter clock / power / format fields
    localparam int CK_FROM_SERIAL = 7;
    localparam int PW_MANUAL = 0;
    localparam int FM_OFFSET_BIN = 7;
    localparam int FM_SRC_HI = 6;
    localparam int FM_SRC_LO = 4;

    // I/Q DAC source codes
    localparam logic [2:0] SRC_TX_FILTER = 3'h0;
    localparam logic [2:0] SRC_DOWN_CONV = 3'h1;
    localparam logic [2:0] SRC_CHIP_TIMING = 3'h2;
    localparam logic [2:0] SRC_ADC = 3'h3;
    localparam logic [2:0] SRC_WINNERS = 3'h4;
    localparam logic [2:0] SRC_WEIGHTS = 3'h5;
    localparam logic [2:0] SRC_TEST_BUS = 3'h6;
    localparam logic [2:0] SRC_CORRELATOR = 3'h7;
    localparam int NUM_WEIGHTS = 16;
    localparam logic [5:0] SYNC_PULSE = 6'h20;

    // slot timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOT_NS = 20000;
    localparam int SAMPLE_EARLY_NS = 15800;
    localparam int SAMPLE_LATE_NS = 18700;
    localparam logic [9:0] SLOT_CYCLES = 10'(SLOT_NS / CLK_PERIOD_NS);
    localparam logic [9:0] SAMPLE_EARLY_CYCLES =
        10'(SAMPLE_EARLY_NS / CLK_PERIOD_NS);
    localparam logic [9:0] SAMPLE_LATE_CYCLES =
        10'(SAMPLE_LATE_NS / CLK_PERIOD_NS);
    localparam logic [9:0] HALF_SLOT_CYCLES = 10'(SLOT_NS / CLK_PERIOD_NS / 2);

endpackage

// file: core/slot_timer.sv
// free running slot counter with sample point and half-slot flag
`timescale 1ns/1ns
`default_nettype none
module slot_timer
    import rx_cfg_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic sample_early, // 1 = 15.8us sample point
    output logic sample_pulse, // one cycle at the sample point
    output logic second_half // level, last half of slot
);
    logic [9:0] count_reg;
    logic [9:0] count_next;
    logic [9:0] sample_at;

    assign count_next = (count_reg == SLOT_CYCLES - 10'h001) ? 10'h000
                        : count_reg + 10'h001;
    assign sample_at = sample_early ? SAMPLE_EARLY_CYCLES
                       : SAMPLE_LATE_CYCLES;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 10'h000;
            sample_pulse <= 1'b0;
            second_half <= 1'b0;
        end else begin
            count_reg <= count_next;
            sample_pulse <= (count_next == sample_at);
            second_half <= (count_next >= HALF_SLOT_CYCLES);
        end
    end
endmodule
`default_nettype wire

// file: core/dac_source_mux.sv
// test multiplexer feeding internal signals onto the I/Q DACs
`timescale 1ns/1ns
`default_nettype none
module dac_source_mux
    import rx_cfg_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic [2:0] source, // selected DAC source
    input wire logic [5:0] tx_filter_i, // transmit
    input wire logic [5:0] tx_filter_q, // transmit
    input wire logic [5:0] down_conv_i, // down conv
    input wire logic [5:0] down_conv_q, // down conv
    input wire logic [5:0] chip_timing_accumulator, // upper six bits
    input wire logic [5:0] adc_i, // I converter sample
    input wire logic [5:0] adc_q, // Q converter sample
    input wire logic [5:0] transform_winner_in_phase, // upper six bits
    input wire logic [5:0] transform_winner_quadrature, // upper six bits
    input wire logic [95:0] channel_matched_filter, // 16 weights, 6 bits
    input wire logic [5:0] test_bus_in, // test bus pins 5:0
    input wire logic test_bus_is_input, // test bus configured as input
    input wire logic [5:0] correlator_i, // correlator / low rate
    input wire logic [5:0] correlator_q, // correlator / low rate
    output logic [5:0] dac_i, // registered I DAC word
    output logic [5:0] dac_q // registered Q DAC word
);
    // even steps show a weight, odd steps the sync pulse
    logic [4:0] step_reg;
    logic [5:0] weight_word;
    logic [5:0] circ_word;
    logic [5:0] bus_word;
    logic [5:0] sel_i;
    logic [5:0] sel_q;

    assign weight_word = channel_matched_filter[step_reg[4:1] * 6 +: 6];
    assign circ_word = step_reg[0] ? SYNC_PULSE : weight_word;
    assign bus_word = test_bus_is_input ? test_bus_in : 6'h00;
    assign sel_i = (source == SRC_TX_FILTER) ? tx_filter_i
                 : (source == SRC_DOWN_CONV) ? down_conv_i
                 : (source == SRC_CHIP_TIMING) ? 6'h00
                 : (source == SRC_ADC) ? adc_i
                 : (source == SRC_WINNERS) ? transform_winner_in_phase
                 : (source == SRC_WEIGHTS) ? circ_word
                 : (source == SRC_TEST_BUS) ? bus_word
                 : correlator_i;
    assign sel_q = (source == SRC_TX_FILTER) ? tx_filter_q
                 : (source == SRC_DOWN_CONV) ? down_conv_q
                 : (source == SRC_CHIP_TIMING) ? chip_timing_accumulator
                 : (source == SRC_ADC) ? adc_q
                 : (source == SRC_WINNERS) ? transform_winner_quadrature
                 : (source == SRC_WEIGHTS) ? circ_word
                 : (source == SRC_TEST_BUS) ? bus_word
                 : correlator_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= 5'h00;
            dac_i <= 6'h00;
            dac_q <= 6'h00;
        end else begin
            step_reg <= step_reg + 5'h01;
            dac_i <= sel_i;
            dac_q <= sel_q;
        end
    end
endmodule
`default_nettype wire

// file: core/rx_config_and_test_regs.sv
// receive configuration and converter test register bank on APB
`timescale 1ns/1ns
`default_nettype none
module rx_config_and_test_regs
    import rx_cfg_pkg::*;
(
    input wire logic pclk, // APB clock, 50 MHz
    input wire logic presetn, // APB reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    // receiver status inputs
    input wire logic packet_active, // a packet is being received
    input wire logic signal_detect, // signal detected
    input wire logic rx_active, // receiver running
    input wire logic header_crc_ok, // pulse, CRC16 ok
    input wire logic sfd_found, // pulse, SFD seen
    input wire logic frame_end, // pulse, frame over
    input wire logic diversity_antenna, // diversity pick
    input wire logic energy_detect, // energy detector
    input wire logic carrier_sense_first, // carrier sense
    input wire logic signal_quality_first, // signal quality
    input wire logic [1:0] cca_mode, // CCA combine mode
    input wire logic cca_sample_early, // 1 = 15.8us sample point
    input wire logic [7:0] short_preamble_length, // short length
    input wire logic [7:0] long_preamble_length, // long length
    // power control inputs
    input wire logic chip_reset, // device reset pin level
    input wire logic transmit_power_enable, // transmit power enable
    input wire logic receive_power_enable, // receive power enable
    // raw converter samples
    input wire logic [5:0] adc_i_raw, // I converter
    input wire logic [5:0] adc_q_raw, // Q converter
    input wire logic [5:0] adc_rf_raw, // RF converter
    // test mux sources
    input wire logic [5:0] tx_filter_i, // transmit filter I
    input wire logic [5:0] tx_filter_q, // transmit filter Q
    input wire logic [5:0] down_conv_i, // down converter I
    input wire logic [5:0] down_conv_q, // down converter Q
    input wire logic [5:0] chip_timing_accumulator, // upper six bits
    input wire logic [5:0] transform_winner_in_phase, // upper six bits
    input wire logic [5:0] transform_winner_quadrature, // upper six bits
    input wire logic [95:0] channel_matched_filter, // 16 weights
    input wire logic [5:0] test_bus_in, // test bus pins 5:0
    input wire logic test_bus_is_input, // test bus set as input
    input wire logic [5:0] correlator_i, // correlator samples I
    input wire logic [5:0] correlator_q, // correlator samples Q
    // control outputs
    output logic agc_freeze_hold, // hold AGC gain
    output logic estimator_clock_en, // estimator / dot product clock
    output logic isi_equalizer_en, // intersymbol equalizer on
    output logic ici_equalizer_en, // interchip equalizer on
    output logic modem_data_ready, // level until frame end
    output logic diversity_switch_en, // diversity may switch
    output logic antenna_select, // antenna select pin
    output logic rx_clock_run, // internal 22/44 MHz clocks run
    output logic adc_ac_coupled, // converter input AC coupled
    output logic [7:0] preamble_length, // preamble length in use
    output logic clear_channel, // clear channel assessment
    output logic [2:0] precursor, // estimate precursor value
    output logic converter_clock_from_serial, // clock via serial pin
    output logic [6:0] converter_clock_en, // 6 TX DAC .. 0 Q A/D
    output logic [6:0] power_down, // 6 standby .. 0 analog standby
    output logic [5:0] adc_i_out, // formatted I sample
    output logic [5:0] adc_q_out, // formatted Q sample
    output logic [5:0] adc_rf_out, // formatted RF sample
    output logic [5:0] dac_i, // I DAC word
    output logic [5:0] dac_q // Q DAC word
);
    logic [7:0] rx_cfg_reg;
    logic [7:0] rxtx_cfg_reg;
    logic [7:0] conv_clk_reg;
    logic [7:0] conv_pwr_reg;
    logic [7:0] conv_fmt_reg;

    // bus decode
    wire sel_rx = (paddr == ADDR_RX_CFG);
    wire sel_rxtx = (paddr == ADDR_RXTX_CFG);
    wire sel_clk = (paddr == ADDR_CONV_CLK);
    wire sel_pwr = (paddr == ADDR_CONV_PWR);
    wire sel_fmt = (paddr == ADDR_CONV_FMT);
    wire hit = sel_rx | sel_rxtx | sel_clk | sel_pwr | sel_fmt;
    // only lane 0 holds a register
    wire wr_en = psel & penable & pready & pwrite & pstrb[0] & hit;
    wire [7:0] wbyte = pwdata[7:0];
    wire [7:0] rd_byte;

    assign rd_byte = sel_rx ? rx_cfg_reg
                   : sel_rxtx ? rxtx_cfg_reg
                   : sel_clk ? conv_clk_reg
                   : sel_pwr ? conv_pwr_reg
                   : sel_fmt ? conv_fmt_reg
                   : 8'h00;

    // ready in the first access cycle, one cycle after setup, so read data can be a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel && !penable) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cfg_reg <= RST_RX_CFG;
            rxtx_cfg_reg <= RST_RXTX_CFG;
            conv_clk_reg <= RST_CONV_CLK;
            conv_pwr_reg <= RST_CONV_PWR;
            conv_fmt_reg <= RST_CONV_FMT;
        end else if (wr_en) begin
            if (sel_rx) begin
                rx_cfg_reg <= wbyte;
            end
            if (sel_rxtx) begin
                rxtx_cfg_reg <= wbyte;
            end
            if (sel_clk) begin
                conv_clk_reg <= wbyte;
            end
            if (sel_pwr) begin
                conv_pwr_reg <= wbyte;
            end
            if (sel_fmt) begin
                conv_fmt_reg <= wbyte;
            end
        end
    end

    // receive path control
    wire cont_clk = rxtx_cfg_reg[RT_CONT_CLK];
    wire est_after_detect = rx_cfg_reg[RX_EST_AFTER_DETECT];
    wire agc_freeze_next = rx_cfg_reg[RX_AGC_FREEZE] & packet_active;
    // continuous clocks win over the estimator gating bit
    wire est_clk_next = cont_clk | ~est_after_detect
                        | signal_detect;
    wire rx_clk_next = cont_clk | rx_active;
    wire ready_event = rx_cfg_reg[RX_READY_AT_SFD] ? sfd_found
                       : header_crc_ok;
    wire slot_second_half;
    wire div_next = ~(rx_cfg_reg[RX_SLOT_DIV] & slot_second_half);
    wire ant_next = rx_cfg_reg[RX_SINGLE_ANT] ? rx_cfg_reg[RX_ANT_CHOICE]
                    : diversity_antenna;
    wire [7:0] pre_len_next = rxtx_cfg_reg[RT_LONG_FOR_SHORT]
                              ? long_preamble_length
                              : short_preamble_length;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_freeze_hold <= 1'b0;
            estimator_clock_en <= 1'b0;
            rx_clock_run <= 1'b0;
            isi_equalizer_en <= 1'b0;
            ici_equalizer_en <= 1'b0;
            diversity_switch_en <= 1'b0;
            antenna_select <= 1'b0;
            preamble_length <= 8'h00;
            adc_ac_coupled <= 1'b0;
            precursor <= 3'h0;
        end else begin
            agc_freeze_hold <= agc_freeze_next;
            estimator_clock_en <= est_clk_next;
            rx_clock_run <= rx_clk_next;
            isi_equalizer_en <= ~rx_cfg_reg[RX_ISI_OFF];
            ici_equalizer_en <= ~rx_cfg_reg[RX_ICI_OFF];
            diversity_switch_en <= div_next;
            antenna_select <= ant_next;
            preamble_length <= pre_len_next;
            adc_ac_coupled <= rxtx_cfg_reg[RT_AC_COUPLE];
            precursor <= rxtx_cfg_reg[RT_PRECURSOR_HI:0];
        end
    end

    // a new ready event beats frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_data_ready <= 1'b0;
        end else if (ready_event) begin
            modem_data_ready <= 1'b1;
        end else if (frame_end) begin
            modem_data_ready <= 1'b0;
        end
    end

    // clear channel assessment
    wire sense_any = carrier_sense_first | signal_quality_first;
    wire cca_raw = (cca_mode == 2'h0) ? energy_detect
                 : (cca_mode == 2'h1) ? sense_any
                 : (cca_mode == 2'h2) ? (energy_detect & sense_any)
                 : (energy_detect | sense_any);
    wire cca_sample;

    slot_timer u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .sample_early(cca_sample_early),
        .sample_pulse(cca_sample),
        .second_half(slot_second_half)
    );

    // raw mode still takes one flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_channel <= 1'b0;
        end else if (!rxtx_cfg_reg[RT_CCA_SAMPLED]) begin
            clear_channel <= cca_raw;
        end else if (cca_sample) begin
            clear_channel <= cca_raw;
        end
    end

    // converter clocks and power
    wire manual_pwr = conv_pwr_reg[PW_MANUAL];
    wire tx_off = ~transmit_power_enable;
    wire rx_off = ~receive_power_enable;
    wire [6:0] auto_pwr = {chip_reset, tx_off, rx_off, tx_off & rx_off,
                           tx_off, rx_off, chip_reset};
    wire [6:0] pwr_next = manual_pwr ? conv_pwr_reg[7:1]
                          : auto_pwr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_clock_from_serial <= 1'b0;
            converter_clock_en <= 7'h00;
            power_down <= 7'h00;
        end else begin
            converter_clock_from_serial <= conv_clk_reg[CK_FROM_SERIAL];
            converter_clock_en <= ~conv_clk_reg[6:0];
            power_down <= pwr_next;
        end
    end

    // converter output format: offset binary flips the sign bit
    wire offset_bin = conv_fmt_reg[FM_OFFSET_BIN];
    wire [5:0] fmt_flip = {offset_bin, 5'h00};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_i_out <= 6'h00;
            adc_q_out <= 6'h00;
            adc_rf_out <= 6'h00;
        end else begin
            adc_i_out <= adc_i_raw ^ fmt_flip;
            adc_q_out <= adc_q_raw ^ fmt_flip;
            adc_rf_out <= adc_rf_raw ^ fmt_flip;
        end
    end

    // ADC source shows formatted words
    dac_source_mux u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .source(conv_fmt_reg[FM_SRC_HI:FM_SRC_LO]),
        .tx_filter_i(tx_filter_i),
        .tx_filter_q(tx_filter_q),
        .down_conv_i(down_conv_i),
        .down_conv_q(down_conv_q),
        .chip_timing_accumulator(chip_timing_accumulator),
        .adc_i(adc_i_out),
        .adc_q(adc_q_out),
        .transform_winner_in_phase(transform_winner_in_phase),
        .transform_winner_quadrature(transform_winner_quadrature),
        .channel_matched_filter(channel_matched_filter),
        .test_bus_in(test_bus_in),
        .test_bus_is_input(test_bus_is_input),
        .correlator_i(correlator_i),
        .correlator_q(correlator_q),
        .dac_i(dac_i),
        .dac_q(dac_q)
    );

endmodule
`default_nettype wire

// file: sim/mac_bus_model.sv
// APB master standing in for the MAC controller
`timescale 1ns/1ns
`default_nettype none
module mac_bus_model (
    input wire logic pclk, // bus clock
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction
    output logic [7:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    output logic [3:0] pstrb, // byte strobes
    input wire logic pready, // ready
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr // error
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: sim/rx_cfg_checker.sv
// port-level assertions for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module rx_cfg_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic packet_active, // packet
    input wire logic signal_detect, // detect
    input wire logic header_crc_ok, // crc
    input wire logic sfd_found, // sfd
    input wire logic frame_end, // end
    input wire logic [5:0] adc_i_raw, // raw
    input wire logic agc_freeze_hold, // agc
    input wire logic estimator_clock_en, // estimator
    input wire logic modem_data_ready, // ready
    input wire logic [5:0] adc_i_out // formatted
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_agc; agc_freeze_hold |-> $past(packet_active); endproperty
    a_agc: assert property (p_agc) else $error("agc hold");
    property p_est; !estimator_clock_en
        |-> !$past(signal_detect); endproperty
    a_est: assert property (p_est) else $error("est gate");
    property p_rdy; $rose(modem_data_ready)
        |-> $past(sfd_found) || $past(header_crc_ok); endproperty
    a_rdy: assert property (p_rdy) else $error("ready rise");
    property p_end; $fell(modem_data_ready) |-> $past(frame_end); endproperty
    a_end: assert property (p_end) else $error("ready fall");
    property p_fmt; $past(presetn)
        |-> adc_i_out[4:0] == $past(adc_i_raw[4:0]); endproperty
    a_fmt: assert property (p_fmt) else $error("format");
    property p_ack; psel && !penable |=> pready; endproperty
    a_ack: assert property (p_ack) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_err; pslverr |-> pready && psel; endproperty
    a_err: assert property (p_err) else $error("stray error");
endmodule
bind rx_config_and_test_regs rx_cfg_checker u_chk (.*);
`default_nettype wire

// file: sim/rx_config_and_test_regs_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module rx_config_and_test_regs_tb;
    import rx_cfg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, short_preamble_length, long_preamble_length;
    logic [7:0] preamble_length;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic packet_active, signal_detect, rx_active, header_crc_ok, sfd_found;
    logic frame_end, diversity_antenna, energy_detect, carrier_sense_first;
    logic signal_quality_first, cca_sample_early, chip_reset;
    logic transmit_power_enable, receive_power_enable, test_bus_is_input;
    logic agc_freeze_hold, estimator_clock_en, isi_equalizer_en;
    logic ici_equalizer_en, modem_data_ready, diversity_switch_en;
    logic antenna_select, rx_clock_run, adc_ac_coupled, clear_channel;
    logic converter_clock_from_serial;
    logic [1:0] cca_mode;
    logic [2:0] precursor;
    logic [6:0] converter_clock_en, power_down;
    logic [5:0] adc_i_raw, adc_q_raw, adc_rf_raw, tx_filter_i, tx_filter_q;
    logic [5:0] down_conv_i, down_conv_q, chip_timing_accumulator;
    logic [5:0] transform_winner_in_phase, transform_winner_quadrature;
    logic [5:0] test_bus_in, correlator_i, correlator_q, adc_i_out;
    logic [5:0] adc_q_out, adc_rf_out, dac_i, dac_q;
    logic [95:0] channel_matched_filter;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    rx_config_and_test_regs u_dut (.*);
    mac_bus_model u_mac (.*);
    task chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [32:0] r;
        u_mac.xfer(1'b1, a, d, r);
    endtask
    task rd(input logic [7:0] a, input logic [8:0] exp);
        logic [32:0] r;
        u_mac.xfer(1'b0, a, 8'h00, r);
        chk(r, {exp[8], 24'h0, exp[7:0]});
    endtask
    task settle;
        repeat (3) @(negedge pclk);
    endtask
    task src(input logic [2:0] s, input logic [11:0] exp);
        wr(ADDR_CONV_FMT, {1'b0, s, 4'h0});
        settle();
        chk({dac_i, dac_q}, exp);
    endtask
    task t_wts;
        logic [5:0] x;
        wr(ADDR_CONV_FMT, 8'h50);
        settle();
        x = dac_i;
        @(negedge pclk);
        chk({x ^ dac_i, x & dac_q}, 12'h2a0);
    endtask
    task t_regs;
        logic [7:0] v [5] = '{8'h31, 8'hb5, 8'hc5, 8'ha5, 8'h80};
        for (int i = 0; i < 5; i++) rd(8'(ADDR_RX_CFG + 8 * i), 9'h000);
        chk({isi_equalizer_en, ici_equalizer_en, diversity_switch_en,
            converter_clock_en}, 10'h3ff);
        for (int i = 0; i < 5; i++) wr(8'(ADDR_RX_CFG + 8 * i), v[i]);
        wr(8'h54, 8'hff);
        settle();
        chk({isi_equalizer_en, ici_equalizer_en, antenna_select}, 0);
        chk({rx_clock_run, adc_ac_coupled, preamble_length, precursor},
            {2'b10, 8'h80, 3'h5});
        chk({converter_clock_from_serial, converter_clock_en}, 8'hba);
        chk(power_down, 7'h52);
        chk({adc_i_out, adc_q_out, adc_rf_out}, 18'h25_9a7);
        rd(8'h54, 9'h100);
        for (int i = 0; i < 5; i++) rd(8'(ADDR_RX_CFG + 8 * i), {1'b0, v[i]});
    endtask
    task t_ctrl;
        wr(ADDR_CONV_PWR, 8'hfe);
        wr(ADDR_RXTX_CFG, 8'h00);
        wr(ADDR_RX_CFG, 8'hc8);
        @(posedge pclk);
        {chip_reset, transmit_power_enable, packet_active, energy_detect,
            header_crc_ok} <= '1;
        @(posedge pclk);
        header_crc_ok <= 1'b0;
        settle();
        chk(power_down, 7'h53);
        chk({agc_freeze_hold, estimator_clock_en, modem_data_ready,
            antenna_select, clear_channel}, 5'b10011);
        @(posedge pclk);
        sfd_found <= 1'b1;
        @(posedge pclk);
        sfd_found <= 1'b0;
        settle();
        chk(modem_data_ready, 1'b1);
        @(posedge pclk);
        frame_end <= 1'b1;
        @(posedge pclk);
        frame_end <= 1'b0;
        settle();
        chk(modem_data_ready, 1'b0);
    endtask
    task finish_test;
        $display("runs %0d fails %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        presetn = 1'b0;
        {packet_active, signal_detect, rx_active, header_crc_ok, sfd_found,
            frame_end, energy_detect, carrier_sense_first, cca_mode,
            signal_quality_first, cca_sample_early, chip_reset,
            transmit_power_enable, receive_power_enable} = '0;
        {diversity_antenna, test_bus_is_input} = 2'b11;
        {short_preamble_length, long_preamble_length} = 16'h3880;
        {adc_i_raw, adc_q_raw, adc_rf_raw} = {6'h05, 6'h06, 6'h07};
        {tx_filter_i, tx_filter_q, down_conv_i, down_conv_q} = 24'h4524d4;
        {chip_timing_accumulator, transform_winner_in_phase} = 12'h556;
        {transform_winner_quadrature, test_bus_in} = 12'h5d8;
        {correlator_i, correlator_q} = 12'h65a;
        channel_matched_filter = {16{6'h2a}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ctrl();
        src(SRC_TX_FILTER, 12'h452);
        src(SRC_DOWN_CONV, 12'h4d4);
        src(SRC_CHIP_TIMING, 12'h015);
        src(SRC_ADC, 12'h146);
        src(SRC_WINNERS, 12'h597);
        src(SRC_TEST_BUS, 12'h618);
        src(SRC_CORRELATOR, 12'h65a);
        t_wts();
        finish_test();
    end
endmodule
`default_nettype wire
